// [hw/uepcs_sync2.v]
// two-flop synchroniser for a bundle of pin-level inputs
`timescale 1ns/1ps
module uepcs_sync2 #(
  parameter W = 1
) (
  pclk,
  presetn,
  din,
  dout
);
  input  wire         pclk;
  input  wire         presetn;
  input  wire [W-1:0] din;
  output wire [W-1:0] dout;
  reg    [W-1:0] s1_ff;
  reg    [W-1:0] s2_ff;

  // first stage feeds the second only, to settle metastability
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= {W{1'b0}};
      s2_ff <= {W{1'b0}};
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
    end
  end
  assign dout = s2_ff;
endmodule

// [hw/uepcs_top.v]
// endpoint configuration, status and frame number bookkeeping behind apb
// Function
// R1 - set frame CRC error flag on corrupt frame, with start-of-frame, clear on bus reset
// R2 - hold 11-bit frame number of last start-of-frame, even corrupt; clear on reset
// R3 - endpoint kind bits 12:11 select control, iso, bulk, interrupt; bus reset clears
// R4 - config bit 9 enables automatic bank switching; bus reset clears
// R5 - config bit 8 sets direction IN; control never IN; bus reset clears
// R6 - three-bit bank size code 8..512 bytes; bus reset clears except endpoint 0
// R7 - bank count code one, two, three banks; 11 reserved; reset clears except ep0
// R8 - software configures control endpoints with a single bank
// R9 - memory claim bit allocates or releases memory; reset clears except ep0
// R10 - writing claim one recomputes config valid bit 18 from limits and memory
// R11 - software rewrites bank count and size when config valid reads zero
// R12 - byte tally counts up on fill, down on drain, per direction
// R13 - tally and active bank may lag access permitted by one clock; access permitted is registered and lags them by one clock instead
// R14 - bit 17 shows direction after SETUP; software writes ignored
// R15 - bit 16 set when bank usable, never during stall or error
// R16 - active bank bits 15:14 report bank 0, 1 or 2
// R17 - occupied bank count reports zero to three busy banks
// R18 - with enable, irq when all IN banks free or all OUT banks busy
// R19 - occupied count updates two to three clocks after bank release
// R20 - toggle field Data0 00, Data1 01, resets to 01
// R21 - IN toggle is next to send; OUT toggle is last received
// R22 - bit 7 set on short OUT packet, or IN dma end with auto switch
`timescale 1ns/1ps
`include "uepcs_defs.vh"
module uepcs_top #(
  parameter EP_NUM = 0
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  usb_bus_reset,
  sof_seen,
  sof_crc_bad,
  sof_frame,
  setup_seen,
  setup_dir_in,
  host_byte,
  sw_byte,
  host_bank_done,
  host_toggle,
  short_rx,
  dma_end_short,
  xfer_error,
  endpoint_irq
);
  input  wire        pclk;
  input  wire        presetn;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [11:0] paddr;
  input  wire [31:0] pwdata;
  output reg  [31:0] prdata;
  output reg         pready;
  output reg         pslverr;
  input  wire        usb_bus_reset;
  input  wire        sof_seen;
  input  wire        sof_crc_bad;
  input  wire [10:0] sof_frame;
  input  wire        setup_seen;
  input  wire        setup_dir_in;
  input  wire        host_byte;
  input  wire        sw_byte;
  input  wire        host_bank_done;
  input  wire        host_toggle;
  input  wire        short_rx;
  input  wire        dma_end_short;
  input  wire        xfer_error;
  output reg         endpoint_irq;

  //////////////////////////////////////////////////////////////////////////////
  // pin-side events come from the usb engine; all pass two flops first
  wire [21:0] pin_s;
  uepcs_sync2 #(.W(22)) uepcs_sync2_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({usb_bus_reset, sof_seen, sof_crc_bad, sof_frame, setup_seen, setup_dir_in,
                host_byte, host_bank_done, host_toggle, short_rx, dma_end_short,
                xfer_error}),
    .dout    (pin_s)
  );
  wire        bus_rst_s = pin_s[21];
  wire        sof_s     = pin_s[20];
  wire        crc_bad_s = pin_s[19];
  wire [10:0] frame_s   = pin_s[18:8];
  wire        setup_s   = pin_s[7];
  wire        sdir_s    = pin_s[6];
  wire        hbyte_s   = pin_s[5];
  wire        hdone_s   = pin_s[4];
  wire        htog_s    = pin_s[3];
  wire        short_s   = pin_s[2];
  wire        dmaend_s  = pin_s[1];
  wire        err_s     = pin_s[0];

  //////////////////////////////////////////////////////////////////////////////
  // state
  reg [10:0] frame_ff;
  reg        ferr_ff;
  reg [1:0]  kind_ff;
  reg        asw_ff;
  reg        dir_ff;
  reg [2:0]  size_ff;
  reg [1:0]  bk_ff;
  reg        claim_ff;
  reg        config_valid_ff;
  reg        cdir_ff;
  reg [10:0] tally_ff;
  reg [1:0]  curbk_ff;
  reg [1:0]  occ_ff;
  reg [1:0]  tog_ff;
  reg        short_ff;
  reg        stall_ff;
  reg        occ_ie_ff;
  reg        dma_oe_ff;
  reg [1:0]  swdly_ff;
  reg        rel_pend_ff;
  reg        acc_ff;
  reg        claim_rechk_ff;

  wire apb_wr  = psel & penable & pwrite & pready;
  wire apb_rd  = psel & penable & ~pwrite & pready;
  wire wr_cfg  = apb_wr & (paddr == `UEPCS_A_CFG);
  wire wr_ctl  = apb_wr & (paddr == `UEPCS_A_CTL);
  wire wr_sclr = apb_wr & (paddr == `UEPCS_A_SCLR);
  wire wr_evt  = apb_wr & (paddr == `UEPCS_A_EVT);
  wire wr_bk   = apb_wr & (paddr == `UEPCS_A_BKCLR) & pwdata[`UEPCS_REL_BIT];
  wire [1:0] nbanks_m1 = bk_ff;
  wire       is_ctrl   = (kind_ff == `UEPCS_KIND_CTRL);

  // software byte strobe: an event register write with bit 0 acts as one byte
  wire sw_b = (wr_evt & pwdata[`UEPCS_EVT_BIT]) | sw_byte;

  //////////////////////////////////////////////////////////////////////////////
  // frame number capture, updated even for a corrupt start-of-frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_ff <= 11'h000;
      ferr_ff  <= 1'b0;
    end else if (bus_rst_s) begin
      frame_ff <= 11'h000; // R2
      ferr_ff  <= 1'b0;    // R1
    end else if (sof_s) begin
      frame_ff <= frame_s;   // R2
      ferr_ff  <= crc_bad_s; // R1
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // allocation check against per-endpoint limits and the shared memory
  wire [12:0] bank_bytes = `UEPCS_BASE_SIZE << size_ff;
  wire [14:0] total_bytes = {2'h0, bank_bytes} * ({13'h0, nbanks_m1} + 15'h1);
  wire fit_ok = (size_ff <= `UEPCS_SIZE_MAX) & (bk_ff <= `UEPCS_BK_MAX) &
                (total_bytes <= {2'h0, `UEPCS_MEM_BYTES}) &
                ~(is_ctrl & (bk_ff != 2'h0));

  // configuration register; ep0 keeps size, banks and claim over a bus reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_ff  <= 2'h0;
      asw_ff   <= 1'b0;
      dir_ff   <= 1'b0;
      size_ff  <= 3'h0;
      bk_ff    <= 2'h0;
      claim_ff <= 1'b0;
    end else if (bus_rst_s) begin
      kind_ff <= 2'h0; // R3
      asw_ff  <= 1'b0; // R4
      dir_ff  <= 1'b0; // R5
      if (EP_NUM != 0) begin
        size_ff  <= 3'h0; // R6
        bk_ff    <= 2'h0; // R7
        claim_ff <= 1'b0; // R9
      end
    end else if (wr_cfg) begin
      kind_ff  <= pwdata[`UEPCS_KIND_HI:`UEPCS_KIND_LO]; // R3
      asw_ff   <= pwdata[`UEPCS_ASW_BIT];                // R4
      // control endpoints cannot be IN
      dir_ff   <= pwdata[`UEPCS_DIR_BIT] &
                  (pwdata[`UEPCS_KIND_HI:`UEPCS_KIND_LO] != `UEPCS_KIND_CTRL); // R5
      size_ff  <= pwdata[`UEPCS_SIZE_HI:`UEPCS_SIZE_LO]; // R6
      bk_ff    <= pwdata[`UEPCS_BK_HI:`UEPCS_BK_LO];     // R7
      claim_ff <= pwdata[`UEPCS_CLAIM_BIT];              // R9
    end
  end

  // check uses the stored fields one cycle after the claim write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      claim_rechk_ff <= 1'b0;
      config_valid_ff       <= 1'b0;
    end else begin
      claim_rechk_ff <= wr_cfg & pwdata[`UEPCS_CLAIM_BIT]; // R10
      if (claim_rechk_ff & ~bus_rst_s)
        config_valid_ff <= fit_ok; // R10
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control stage direction, set only by the host side
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cdir_ff <= 1'b0;
    else if (bus_rst_s)
      cdir_ff <= 1'b0;
    else if (setup_s)
      cdir_ff <= sdir_s; // R14
  end

  //////////////////////////////////////////////////////////////////////////////
  // byte tally and bank bookkeeping
  wire fill_b  = dir_ff ? sw_b : hbyte_s;   // R12
  wire drain_b = dir_ff ? hbyte_s : sw_b;   // R12
  wire [1:0] nxt_bank = (curbk_ff == nbanks_m1) ? 2'h0 : curbk_ff + 2'h1;
  // release after software clears bank control lands two clocks later
  wire rel_fire = rel_pend_ff & (swdly_ff == 2'h0);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tally_ff    <= 11'h000;
      curbk_ff    <= 2'h0;
      occ_ff      <= 2'h0;
      swdly_ff    <= 2'h0;
      rel_pend_ff <= 1'b0;
    end else if (bus_rst_s) begin
      tally_ff    <= 11'h000;
      curbk_ff    <= 2'h0;
      occ_ff      <= 2'h0;
      swdly_ff    <= 2'h0;
      rel_pend_ff <= 1'b0;
    end else begin
      if (fill_b & ~drain_b)
        tally_ff <= tally_ff + 11'h001; // R12
      else if (drain_b & ~fill_b & (tally_ff != 11'h000))
        tally_ff <= tally_ff - 11'h001; // R12
      if (wr_bk) begin
        rel_pend_ff <= 1'b1;
        swdly_ff    <= `UEPCS_SW_DELAY - 2'h1;
      end else if (rel_pend_ff && swdly_ff != 2'h0)
        swdly_ff <= swdly_ff - 2'h1;
      if (rel_fire) begin
        rel_pend_ff <= 1'b0;
        if (!is_ctrl)
          curbk_ff <= nxt_bank; // R16
        tally_ff <= 11'h000;
      end
      // software releases fill IN banks, host completion drains them
      if (dir_ff) begin
        if (rel_fire & ~hdone_s & (occ_ff <= nbanks_m1))
          occ_ff <= occ_ff + 2'h1; // R19
        else if (hdone_s & ~rel_fire & (occ_ff != 2'h0))
          occ_ff <= occ_ff - 2'h1; // R17
      end else begin
        if (hdone_s & ~rel_fire & (occ_ff <= nbanks_m1))
          occ_ff <= occ_ff + 2'h1; // R17
        else if (rel_fire & ~hdone_s & (occ_ff != 2'h0))
          occ_ff <= occ_ff - 2'h1; // R19
      end
    end
  end

  // access permitted lags tally and bank by one clock, being registered from the bank state
  wire bank_full = (occ_ff > nbanks_m1);
  wire nxt_acc = ~stall_ff & ~err_s & ~is_ctrl &
                 (dir_ff ? ~bank_full : (occ_ff != 2'h0)); // R15 R13
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      acc_ff <= 1'b0;
    else
      acc_ff <= nxt_acc; // R15
  end

  //////////////////////////////////////////////////////////////////////////////
  // data toggle: IN advances per bank sent, OUT records what arrived
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tog_ff <= `UEPCS_TOG_RST; // R20
    else if (bus_rst_s)
      tog_ff <= `UEPCS_TOG_RST; // R20
    else if (hdone_s) begin
      if (dir_ff)
        tog_ff <= {1'b0, ~tog_ff[0]}; // R21
      else
        tog_ff <= {1'b0, htog_s};     // R21
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // short frame flag and control bits; a set beats a same-cycle clear
  wire short_set = ~is_ctrl & (dir_ff ? (dmaend_s & dma_oe_ff & asw_ff) : short_s); // R22
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_ff  <= 1'b0;
      stall_ff  <= 1'b0;
      occ_ie_ff <= 1'b0;
      dma_oe_ff <= 1'b0;
    end else if (bus_rst_s) begin
      short_ff  <= 1'b0;
      stall_ff  <= 1'b0;
      occ_ie_ff <= 1'b0;
      dma_oe_ff <= 1'b0;
    end else begin
      if (short_set)
        short_ff <= 1'b1; // R22
      else if (wr_sclr & pwdata[`UEPCS_SHORT_BIT])
        short_ff <= 1'b0;
      if (wr_ctl) begin
        occ_ie_ff <= pwdata[`UEPCS_CTL_IE_BIT];
        stall_ff  <= pwdata[`UEPCS_CTL_STL_BIT];
        dma_oe_ff <= pwdata[`UEPCS_CTL_DMA_BIT];
      end
    end
  end

  // endpoint interrupt from the occupied bank condition
  wire irq_cond = occ_ie_ff & (dir_ff ? (occ_ff == 2'h0) : bank_full); // R18
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      endpoint_irq <= 1'b0;
    else
      endpoint_irq <= irq_cond; // R18
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, unmapped addresses answer with pslverr
  reg [31:0] rd_mux;
  reg        hit;
  always @* begin
    rd_mux = 32'h00000000;
    hit    = 1'b1;
    case (paddr)
      `UEPCS_A_FRAME:
        rd_mux = {16'h0000, ferr_ff, 1'b0, frame_ff, 3'h0};
      `UEPCS_A_CFG:
        rd_mux = {19'h00000, kind_ff, 1'b0, asw_ff, dir_ff, 1'b0, size_ff, bk_ff,
                  claim_ff, 1'b0};
      `UEPCS_A_STA:
        rd_mux = {1'b0, tally_ff, 1'b0, config_valid_ff, cdir_ff, acc_ff, curbk_ff, occ_ff,
                  2'h0, tog_ff, short_ff, 7'h00};
      `UEPCS_A_CTL:
        rd_mux = {29'h00000000, dma_oe_ff, stall_ff, occ_ie_ff};
      `UEPCS_A_EVT, `UEPCS_A_SCLR, `UEPCS_A_BKCLR:
        rd_mux = 32'h00000000;
      default:
        hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      // ready is registered in the first access cycle, high in the second, drops after the handshake
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_mux;
      else
        prdata <= 32'h00000000;
    end
  end
endmodule

// [shared/uepcs_defs.vh]
// constants for the usb endpoint configuration and status block
`ifndef UEPCS_DEFS_VH
`define UEPCS_DEFS_VH
`define UEPCS_A_FRAME      12'h020
`define UEPCS_A_CFG        12'h100
`define UEPCS_A_STA        12'h130
`define UEPCS_A_EVT        12'h1F0
`define UEPCS_A_CTL        12'h1F4
`define UEPCS_A_SCLR       12'h160
`define UEPCS_A_BKCLR      12'h1F8
`define UEPCS_STA_RST      32'h00000100
`define UEPCS_FRAME_HI     10
`define UEPCS_FRAME_LO     0
`define UEPCS_FERR_BIT     15
`define UEPCS_FRAME_NUMBER_SHIFT   3
`define UEPCS_KIND_HI      12
`define UEPCS_KIND_LO      11
`define UEPCS_ASW_BIT      9
`define UEPCS_DIR_BIT      8
`define UEPCS_SIZE_HI      6
`define UEPCS_SIZE_LO      4
`define UEPCS_BK_HI        3
`define UEPCS_BK_LO        2
`define UEPCS_CLAIM_BIT    1
`define UEPCS_TALLY_LO     20
`define UEPCS_CONFIG_VALID_BIT    18
`define UEPCS_CDIR_BIT     17
`define UEPCS_ACC_BIT      16
`define UEPCS_CURBK_LO     14
`define UEPCS_OCC_LO       12
`define UEPCS_TOG_LO       8
`define UEPCS_SHORT_BIT    7
`define UEPCS_CTL_IE_BIT   0
`define UEPCS_CTL_STL_BIT  1
`define UEPCS_CTL_DMA_BIT  2
`define UEPCS_EVT_BIT      0
`define UEPCS_REL_BIT      0
`define UEPCS_KIND_CTRL    2'h0
`define UEPCS_TOG_RST      2'h1
`define UEPCS_SIZE_MAX     3'h6
`define UEPCS_BK_MAX       2'h2
`define UEPCS_MEM_BYTES    13'h0600
`define UEPCS_SW_DELAY     2'h2
`define UEPCS_BASE_SIZE    13'h0008
`endif

// [tb/uepcs_host_model.sv]
// usb host side stand-in driving the bus-facing pins of the endpoint block
`timescale 1ns/1ps
module uepcs_host_model (
  input  wire        pclk,
  output reg         usb_bus_reset,
  output reg         sof_seen,
  output reg         sof_crc_bad,
  output reg  [10:0] sof_frame,
  output reg         setup_seen,
  output reg         setup_dir_in,
  output reg         host_byte,
  output reg         host_bank_done,
  output reg         host_toggle,
  output reg         short_rx,
  output reg         dma_end_short,
  output reg         xfer_error
);
  ////////////////////////////////////////////////////////////////////////////////
  // all pins quiet at time zero
  initial begin
    {usb_bus_reset, sof_seen, sof_crc_bad, setup_seen, setup_dir_in} = 5'h00;
    {host_byte, host_bank_done, host_toggle, short_rx, dma_end_short, xfer_error} = 6'h00;
    sof_frame = 11'h000;
  end

  // pins pass two flops, so let the result land before anyone reads it
  task settle;
    repeat (5) @(posedge pclk);
  endtask

  // frame packet; qualifiers then show the inverse so a late capture is caught
  task sof(input [10:0] f, input bad);
    begin
      sof_seen <= 1'h1;
      sof_frame <= f;
      sof_crc_bad <= bad;
      @(posedge pclk);
      sof_seen <= 1'h0;
      sof_frame <= ~f;
      sof_crc_bad <= ~bad;
      settle;
    end
  endtask

  // setup packet announcing the direction of the next stage
  task setup(input dir_in);
    begin
      setup_seen <= 1'h1;
      setup_dir_in <= dir_in;
      @(posedge pclk);
      setup_seen <= 1'h0;
      setup_dir_in <= ~dir_in;
      settle;
    end
  endtask

  // a level held n cycles moves n bytes
  task bytes(input integer n);
    begin
      host_byte <= 1'h1;
      repeat (n) @(posedge pclk);
      host_byte <= 1'h0;
      settle;
    end
  endtask

  task bank_done(input tog);
    begin
      host_bank_done <= 1'h1;
      host_toggle <= tog;
      @(posedge pclk);
      host_bank_done <= 1'h0;
      host_toggle <= ~tog;
      settle;
    end
  endtask

  task bus_reset;
    begin
      usb_bus_reset <= 1'h1;
      repeat (3) @(posedge pclk);
      usb_bus_reset <= 1'h0;
      settle;
    end
  endtask

  // short packet: OUT reception, or an IN dma end when dma is one
  task short_pkt(input dma);
    begin
      short_rx <= !dma;
      dma_end_short <= dma;
      @(posedge pclk);
      {short_rx, dma_end_short} <= 2'h0;
      settle;
    end
  endtask

  task set_error(input v);
    begin
      xfer_error <= v;
      settle;
    end
  endtask
endmodule

// [tb/uepcs_top_monitor.sv]
// concurrent checks on the apb answer and the status words of the endpoint block
`timescale 1ns/1ps
`include "uepcs_defs.vh"
module uepcs_top_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        xfer_error
);
  reg  [2:0] err_run_ff;
  wire       rd_done;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  // read completing this cycle
  assign rd_done = pready && psel && !pwrite;

  // run length of the error pin; saturates so a long error never wraps under the limit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      err_run_ff <= 3'h0;
    else if (!xfer_error)
      err_run_ff <= 3'h0;
    else if (err_run_ff != 3'h7)
      err_run_ff <= err_run_ff + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_wait_a: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("ready not on the second access cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  err_zero_data_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  frame_layout_a: assert property (
    rd_done && paddr == `UEPCS_A_FRAME |->
      prdata[31:16] == 16'h0 && !prdata[14] && prdata[2:0] == 3'h0)
    else $error("frame word has bits outside its fields");
  toggle_code_a: assert property (
    rd_done && paddr == `UEPCS_A_STA |-> !prdata[9] && prdata[11:10] == 2'h0)
    else $error("reserved toggle code reported");
  bank_code_a: assert property (
    rd_done && paddr == `UEPCS_A_STA |-> prdata[15:14] != 2'h3)
    else $error("reserved active bank code reported");
  ctrl_dir_out_a: assert property (
    rd_done && paddr == `UEPCS_A_CFG && prdata[12:11] == `UEPCS_KIND_CTRL |-> !prdata[8])
    else $error("control endpoint reads back as IN");
  access_error_a: assert property (
    rd_done && paddr == `UEPCS_A_STA && err_run_ff >= 3'h6 |-> !prdata[16])
    else $error("access permitted during an error");
endmodule

bind uepcs_top uepcs_top_monitor uepcs_top_monitor_inst (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .xfer_error(xfer_error)
);

// [tb/usb_device_endpoint_cfg_status_bench.sv]
// self-checking bench for the endpoint configuration and status block
`timescale 1ns/1ps
`include "uepcs_defs.vh"
module usb_device_endpoint_cfg_status_bench;
  reg         pclk, presetn, psel, penable, pwrite, sw_byte, err_seen;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd, v;
  wire [31:0] prdata;
  wire        pready, pslverr, endpoint_irq, ubr, sofs, sofb, sets, setd;
  wire        hb, hbd, htg, srx, des, xer;
  wire [10:0] sfr;
  integer     fail_count, total_checks, k;
  reg  [31:0] vcfg [0:5];

  always #12.5 pclk = ~pclk;

  uepcs_top #(.EP_NUM(1)) uepcs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .usb_bus_reset(ubr), .sof_seen(sofs),
    .sof_crc_bad(sofb), .sof_frame(sfr), .setup_seen(sets), .setup_dir_in(setd),
    .host_byte(hb), .sw_byte(sw_byte), .host_bank_done(hbd), .host_toggle(htg),
    .short_rx(srx), .dma_end_short(des), .xfer_error(xer), .endpoint_irq(endpoint_irq));
  uepcs_host_model uepcs_host_model_inst (.pclk(pclk), .usb_bus_reset(ubr), .sof_seen(sofs),
    .sof_crc_bad(sofb), .sof_frame(sfr), .setup_seen(sets), .setup_dir_in(setd),
    .host_byte(hb), .host_bank_done(hbd), .host_toggle(htg), .short_rx(srx),
    .dma_end_short(des), .xfer_error(xer));

  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task check(input string nm, input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // one apb transfer; held until ready is sampled high, bounded wait
  task apb(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      // ready stands a whole cycle: look mid-cycle, complete at the next rising edge
      @(negedge pclk);
      while (pready !== 1'h1) begin
        n = n + 1;
        if (n > 16) begin
          fail_count = fail_count + 1;
          final_report;
        end
        @(negedge pclk);
      end
      rd = prdata;
      err_seen = pslverr;
      @(posedge pclk);
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  task rdchk(input [11:0] a, input [31:0] m, input [31:0] e, input string nm);
    begin
      apb(a, 1'h0, 32'h0);
      check(nm, rd & m, e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task reset_values;
    begin
      rdchk(`UEPCS_A_CFG, 32'hFFFFFFFF, 32'h0, "cfg reset");
      rdchk(`UEPCS_A_STA, 32'hFFFFFFFF, `UEPCS_STA_RST, "sta reset");
      rdchk(`UEPCS_A_FRAME, 32'hFFFFFFFF, 32'h0, "frame reset");
      rdchk(12'h1FC, 32'hFFFFFFFF, 32'h0, "unmapped data");
      check("unmapped err", {31'h0, err_seen}, 32'h1);
    end
  endtask

  task frame_capture;
    begin
      uepcs_host_model_inst.sof(11'h5A5, 1'h0);
      rdchk(`UEPCS_A_FRAME, 32'hFFFFFFFF, 32'h00002D28, "frame good");
      uepcs_host_model_inst.sof(11'h7FF, 1'h1);
      rdchk(`UEPCS_A_FRAME, 32'hFFFFFFFF, 32'h0000BFF8, "frame corrupt");
      uepcs_host_model_inst.bus_reset;
      rdchk(`UEPCS_A_FRAME, 32'hFFFFFFFF, 32'h0, "frame bus reset");
    end
  endtask

  // every kind with IN, auto switch, size code k; control keeps one bank
  task cfg_fields;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        v = (k << 11) | 32'h300 | (k << 4) | (k != 0 ? 32'h4 : 32'h0);
        apb(`UEPCS_A_CFG, 1'h1, v);
        rdchk(`UEPCS_A_CFG, 32'hFFFFFFFF, k == 0 ? v & 32'hFFFFFEFF : v, "cfg");
      end
    end
  endtask

  // limits of bank count and size against memory; rewrite after a refusal
  task cfg_valid;
    begin
      for (k = 0; k < 6; k = k + 1) begin
        apb(`UEPCS_A_CFG, 1'h1, vcfg[k]);
        rdchk(`UEPCS_A_STA, 32'h40000, {8'h0, 6'h23 >> k, 18'h0} & 32'h40000, "ok");
      end
      uepcs_host_model_inst.bus_reset;
      rdchk(`UEPCS_A_CFG, 32'hFFFFFFFF, 32'h0, "cfg bus reset");
    end
  endtask

  task ctrl_dir;
    begin
      uepcs_host_model_inst.setup(1'h1);
      rdchk(`UEPCS_A_STA, 32'h20000, 32'h20000, "dir in");
      apb(`UEPCS_A_STA, 1'h1, 32'h0);
      rdchk(`UEPCS_A_STA, 32'h20000, 32'h20000, "dir kept");
      uepcs_host_model_inst.setup(1'h0);
      apb(`UEPCS_A_STA, 1'h1, 32'h20000);
      rdchk(`UEPCS_A_STA, 32'h20000, 32'h0, "dir out");
    end
  endtask

  // bulk OUT, one bank: tally, short flag, banks, interrupt and error
  task data_path;
    begin
      apb(`UEPCS_A_CFG, 1'h1, 32'h1032);
      uepcs_host_model_inst.bytes(5);
      rdchk(`UEPCS_A_STA, 32'h7FF00000, 32'h00500000, "tally fill");
      sw_byte <= 1'h1;
      repeat (2) @(posedge pclk);
      sw_byte <= 1'h0;
      apb(`UEPCS_A_EVT, 1'h1, 32'h1);
      rdchk(`UEPCS_A_STA, 32'h7FF00000, 32'h00200000, "tally drain");
      uepcs_host_model_inst.short_pkt(1'h0);
      rdchk(`UEPCS_A_STA, 32'h80, 32'h80, "short set");
      apb(`UEPCS_A_SCLR, 1'h1, 32'h80);
      rdchk(`UEPCS_A_STA, 32'h80, 32'h0, "short clear");
      uepcs_host_model_inst.bank_done(1'h0);
      rdchk(`UEPCS_A_STA, 32'h3300, 32'h1000, "busy toggle0");
      apb(`UEPCS_A_CTL, 1'h1, 32'h1);
      repeat (2) @(posedge pclk);
      check("irq full", {31'h0, endpoint_irq}, 32'h1);
      apb(`UEPCS_A_BKCLR, 1'h1, 32'h1);
      repeat (4) @(posedge pclk);
      check("irq freed", {31'h0, endpoint_irq}, 32'h0);
      rdchk(`UEPCS_A_STA, 32'h3000, 32'h0, "busy freed");
      apb(`UEPCS_A_CTL, 1'h1, 32'h0);
      uepcs_host_model_inst.bank_done(1'h1);
      check("irq masked", {31'h0, endpoint_irq}, 32'h0);
      rdchk(`UEPCS_A_STA, 32'h300, 32'h100, "toggle1");
      uepcs_host_model_inst.set_error(1'h1);
      rdchk(`UEPCS_A_STA, 32'h10000, 32'h0, "access in error");
      uepcs_host_model_inst.set_error(1'h0);
    end
  endtask

  // bulk IN, auto switch, two banks: fill, release, dma end short, stall, free irq
  task in_path;
    begin
      uepcs_host_model_inst.bus_reset;
      apb(`UEPCS_A_CFG, 1'h1, 32'h1336);
      apb(`UEPCS_A_CTL, 1'h1, 32'h4);
      rdchk(`UEPCS_A_STA, 32'h1F000, 32'h10000, "in idle");
      uepcs_host_model_inst.short_pkt(1'h1);
      rdchk(`UEPCS_A_STA, 32'h80, 32'h80, "short dma end");
      apb(`UEPCS_A_EVT, 1'h1, 32'h1);
      rdchk(`UEPCS_A_STA, 32'h7FF00000, 32'h00100000, "in tally");
      apb(`UEPCS_A_BKCLR, 1'h1, 32'h1);
      rdchk(`UEPCS_A_STA, 32'h7FF3F000, 32'h00015000, "in released");
      apb(`UEPCS_A_CTL, 1'h1, 32'h6);
      rdchk(`UEPCS_A_STA, 32'h10000, 32'h0, "access stall");
      apb(`UEPCS_A_CTL, 1'h1, 32'h1);
      uepcs_host_model_inst.bank_done(1'h1);
      check("irq in free", {31'h0, endpoint_irq}, 32'h1);
      rdchk(`UEPCS_A_STA, 32'h3300, 32'h0, "in sent");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    vcfg[0] = 32'h1066;
    vcfg[1] = 32'h106A;
    vcfg[2] = 32'h106E;
    vcfg[3] = 32'h0036;
    vcfg[4] = 32'h1072;
    vcfg[5] = 32'h0032;
    {pclk, presetn, psel, penable, pwrite, sw_byte} = 6'h00;
    paddr = 12'h0;
    pwdata = 32'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    reset_values;
    frame_capture;
    cfg_fields;
    cfg_valid;
    ctrl_dir;
    data_path;
    in_path;
    final_report;
  end
endmodule
